// [logic/t1cd_timer.sv]
/*
  Timer slice: 10-bit counter, compare D, compare C top, interrupt mask
  and flags, vector selection and the shared dead-time register.
  Assumes the CPU I/O bus, the prescaler tick and the vector acknowledge
  all run on mclk; compare A and B events come from the rest of the timer.
*/
`default_nettype none
module t1cd_timer (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [5:0] io_addr,
  input  wire logic [7:0] io_wdata,
  input  wire logic       io_we,
  input  wire logic       io_re,
  output logic      [7:0] io_rdata,
  input  wire logic       timer_tick,
  input  wire logic       pwm_mode,
  input  wire logic [1:0] wgm,
  input  wire logic [1:0] com_d,
  input  wire logic       gie,
  input  wire logic       cmp_a_evt,
  input  wire logic       cmp_b_evt,
  input  wire logic       irq_ack,
  input  wire logic [4:0] irq_ack_vec,
  output logic            irq_req,
  output logic      [4:0] irq_vec,
  output logic      [9:0] counter_value,
  output logic      [9:0] top_compare_value,
  output logic            cmp_d_match,
  output logic            overflow_evt,
  output logic            pwm_output,
  output logic            pwm_output_n
);

  typedef struct packed {
    logic [9:0] cnt;
    logic       dir_down;
    logic [9:0] top;
    logic [9:0] cmpd;
    logic [1:0] hb;
    logic [7:0] dt;
    logic [3:0] mask;
    logic [7:0] rdata;
    logic       wave;
    logic       cmpd_evt;
    logic       ovf_evt;
    logic       irq_req;
    logic [4:0] irq_vec;
  } t1cd_top_state_t;

  t1cd_top_state_t q_reg;
  t1cd_top_state_t q_next;

  logic       cnt_wr;
  logic       flag_wr;
  logic [3:0] pend;
  logic [9:0] top_eff;
  logic       dual;

  t1cd_link_if lk ();

  // --------------------------------------------------------------
  // Bit packing between flag vector and register byte
  // --------------------------------------------------------------
  function automatic logic [7:0] to_byte(input logic [3:0] v);
    logic [7:0] b;
    b = 8'h00;
    b[t1cd_pkg::BIT_CMP_D] = v[t1cd_pkg::FI_D];
    b[t1cd_pkg::BIT_CMP_A] = v[t1cd_pkg::FI_A];
    b[t1cd_pkg::BIT_CMP_B] = v[t1cd_pkg::FI_B];
    b[t1cd_pkg::BIT_OVF]   = v[t1cd_pkg::FI_OVF];
    return b;
  endfunction : to_byte

  function automatic logic [3:0] from_byte(input logic [7:0] b);
    logic [3:0] v;
    v = 4'h0;
    v[t1cd_pkg::FI_D]   = b[t1cd_pkg::BIT_CMP_D];
    v[t1cd_pkg::FI_A]   = b[t1cd_pkg::BIT_CMP_A];
    v[t1cd_pkg::FI_B]   = b[t1cd_pkg::BIT_CMP_B];
    v[t1cd_pkg::FI_OVF] = b[t1cd_pkg::BIT_OVF];
    return v;
  endfunction : from_byte

  function automatic logic [3:0] vec_decode(input logic [4:0] vec);
    logic [3:0] v;
    v = 4'h0;
    case (vec)
      t1cd_pkg::VEC_CMP_D: v[t1cd_pkg::FI_D] = 1'b1;
      t1cd_pkg::VEC_CMP_A: v[t1cd_pkg::FI_A] = 1'b1;
      t1cd_pkg::VEC_CMP_B: v[t1cd_pkg::FI_B] = 1'b1;
      t1cd_pkg::VEC_OVF:   v[t1cd_pkg::FI_OVF] = 1'b1;
      default:             v = 4'h0;
    endcase
    return v;
  endfunction : vec_decode

  // --------------------------------------------------------------
  // Decodes and links to the submodules
  // --------------------------------------------------------------
  assign cnt_wr  = io_we && (io_addr == t1cd_pkg::ADDR_CNT);
  assign flag_wr = io_we && (io_addr == t1cd_pkg::ADDR_FLAGS);
  assign dual    = pwm_mode && wgm[t1cd_pkg::WGM_DUAL];
  assign top_eff = (q_reg.top < t1cd_pkg::TOP_MIN) ? t1cd_pkg::TOP_MIN : q_reg.top;
  assign pend    = lk.flags & q_reg.mask & {4{gie}};

  assign lk.tick    = timer_tick;
  assign lk.wave    = q_reg.wave;
  assign lk.dt_true = q_reg.dt[t1cd_pkg::DT_TRUE_HI:t1cd_pkg::DT_TRUE_LO];
  assign lk.dt_comp = q_reg.dt[t1cd_pkg::DT_COMP_HI:t1cd_pkg::DT_COMP_LO];
  assign lk.set_evt = {q_reg.cmpd_evt, cmp_a_evt, cmp_b_evt, q_reg.ovf_evt};
  assign lk.w1c     = flag_wr ? from_byte(io_wdata) : 4'h0;
  assign lk.ack     = irq_ack ? vec_decode(irq_ack_vec) : 4'h0;

  t1cd_flags u_flags (
    .mclk  (mclk),
    .rst_b (rst_b),
    .lk    (lk.fl_own)
  );

  t1cd_deadtime u_deadtime (
    .mclk  (mclk),
    .rst_b (rst_b),
    .lk    (lk.dt_gen)
  );

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    logic [9:0] nxt;
    logic [9:0] wide;
    nxt  = q_reg.cnt;
    wide = {q_reg.hb, io_wdata};

    q_next          = q_reg;
    q_next.cmpd_evt = 1'b0;
    q_next.ovf_evt  = 1'b0;
    if (!dual) begin
      q_next.dir_down = 1'b0;
    end

    // Counting, top and bottom handling
    if (timer_tick && !cnt_wr) begin
      if (!dual || !q_reg.dir_down) begin
        if (q_reg.cnt >= top_eff) begin
          if (dual) begin
            q_next.dir_down = 1'b1;
            nxt = q_reg.cnt - t1cd_pkg::CNT_ONE;
          end else begin
            nxt = t1cd_pkg::CNT_ZERO;
            q_next.ovf_evt = 1'b1;
          end
        end else begin
          nxt = q_reg.cnt + t1cd_pkg::CNT_ONE;
        end
      end else if (q_reg.cnt <= t1cd_pkg::CNT_ONE) begin
        nxt = t1cd_pkg::CNT_ZERO;
        q_next.dir_down = 1'b0;
        q_next.ovf_evt  = 1'b1;
      end else begin
        nxt = q_reg.cnt - t1cd_pkg::CNT_ONE;
      end
      q_next.cnt      = nxt;
      q_next.cmpd_evt = (nxt == q_reg.cmpd);
    end

    // Output action on compare D
    if (q_reg.cmpd_evt) begin
      case (com_d)
        t1cd_pkg::COM_TOGGLE: q_next.wave = !q_reg.wave;
        t1cd_pkg::COM_CLEAR:  q_next.wave = 1'b0;
        t1cd_pkg::COM_SET:    q_next.wave = 1'b1;
        default:              q_next.wave = q_reg.wave;
      endcase
    end

    // Register reads
    if (io_re) begin
      case (io_addr)
        t1cd_pkg::ADDR_FLAGS: q_next.rdata = to_byte(lk.flags);
        t1cd_pkg::ADDR_MASK:  q_next.rdata = to_byte(q_reg.mask);
        t1cd_pkg::ADDR_HB:    q_next.rdata = {6'h00, q_reg.hb};
        t1cd_pkg::ADDR_DT:    q_next.rdata = q_reg.dt;
        t1cd_pkg::ADDR_CNT: begin
          q_next.rdata = q_reg.cnt[7:0];
          q_next.hb    = q_reg.cnt[9:8];
        end
        t1cd_pkg::ADDR_TOP: begin
          q_next.rdata = top_eff[7:0];
          q_next.hb    = top_eff[9:8];
        end
        t1cd_pkg::ADDR_CMPD: begin
          q_next.rdata = q_reg.cmpd[7:0];
          q_next.hb    = q_reg.cmpd[9:8];
        end
        default:              q_next.rdata = 8'h00;
      endcase
    end

    // Register writes; counter write suppresses counting
    if (io_we) begin
      case (io_addr)
        t1cd_pkg::ADDR_MASK: q_next.mask = from_byte(io_wdata);
        t1cd_pkg::ADDR_HB:   q_next.hb   = io_wdata[1:0];
        t1cd_pkg::ADDR_DT:   q_next.dt   = io_wdata;
        t1cd_pkg::ADDR_CMPD: q_next.cmpd = wide;
        t1cd_pkg::ADDR_TOP: begin
          q_next.top = (wide < t1cd_pkg::TOP_MIN) ? t1cd_pkg::TOP_MIN : wide;
        end
        t1cd_pkg::ADDR_CNT: begin
          q_next.cnt      = wide;
          q_next.dir_down = 1'b0;
        end
        default: q_next.mask = q_next.mask;
      endcase
    end

    // Vector selection, lowest vector first
    q_next.irq_req = |pend;
    if (pend[t1cd_pkg::FI_A]) begin
      q_next.irq_vec = t1cd_pkg::VEC_CMP_A;
    end else if (pend[t1cd_pkg::FI_OVF]) begin
      q_next.irq_vec = t1cd_pkg::VEC_OVF;
    end else if (pend[t1cd_pkg::FI_B]) begin
      q_next.irq_vec = t1cd_pkg::VEC_CMP_B;
    end else if (pend[t1cd_pkg::FI_D]) begin
      q_next.irq_vec = t1cd_pkg::VEC_CMP_D;
    end else begin
      q_next.irq_vec = t1cd_pkg::VEC_NONE;
    end
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign io_rdata          = q_reg.rdata;
  assign irq_req           = q_reg.irq_req;
  assign irq_vec           = q_reg.irq_vec;
  assign counter_value     = q_reg.cnt;
  assign top_compare_value = top_eff;
  assign cmp_d_match       = q_reg.cmpd_evt;
  assign overflow_evt      = q_reg.ovf_evt;
  assign pwm_output        = lk.out_true;
  assign pwm_output_n      = lk.out_comp;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_cmpd_on_count: assert property (
    q_reg.cmpd_evt |-> $past(timer_tick) && q_reg.cnt == $past(q_reg.cmpd))
    else $error("compare D event without counting to it");

  a_cmpd_no_write: assert property (
    cnt_wr |=> !q_reg.cmpd_evt)
    else $error("counter write produced a compare D event");

  a_cmpd_flag_late: assert property (
    q_reg.cmpd_evt |-> !lk.flags[t1cd_pkg::FI_D] || $past(lk.flags[t1cd_pkg::FI_D])
      ##2 lk.flags[t1cd_pkg::FI_D])
    else $error("compare D flag timing wrong");

  a_wave_set_act: assert property (
    q_reg.cmpd_evt && com_d == t1cd_pkg::COM_SET |=> q_reg.wave)
    else $error("set action not applied on compare D");

  a_irq_gate: assert property (
    irq_req |-> $past(gie) && (($past(lk.flags) & $past(q_reg.mask)) != 4'h0))
    else $error("request raised without enable and flag");

  a_vec_cmp_d: assert property (
    irq_req && irq_vec == t1cd_pkg::VEC_CMP_D |-> $past(pend) == 4'h8)
    else $error("compare D vector chosen wrongly");

  a_vec_ovf: assert property (
    $past(pend[t1cd_pkg::FI_OVF]) && !$past(pend[t1cd_pkg::FI_A]) |-> irq_vec == t1cd_pkg::VEC_OVF)
    else $error("overflow vector not chosen");

  a_ack_clears_d: assert property (
    irq_ack && irq_ack_vec == t1cd_pkg::VEC_CMP_D && !$past(q_reg.cmpd_evt)
      |=> !lk.flags[t1cd_pkg::FI_D])
    else $error("acknowledge did not clear compare D flag");

  a_w1c_ovf: assert property (
    flag_wr && io_wdata[t1cd_pkg::BIT_OVF] && !q_reg.ovf_evt && !irq_ack
      |-> ##2 !lk.flags[t1cd_pkg::FI_OVF])
    else $error("write one did not clear overflow flag");

  a_ovf_single: assert property (
    q_reg.ovf_evt && !$past(dual) |-> q_reg.cnt == 10'h000 && $past(q_reg.cnt) >= $past(top_eff))
    else $error("single-slope overflow not at top wrap");

  a_ovf_dual: assert property (
    q_reg.ovf_evt && $past(dual) |-> q_reg.cnt == 10'h000 && $past(q_reg.dir_down))
    else $error("dual-slope overflow not at bottom");

  a_set_wins: assert property (
    (lk.set_evt & lk.w1c) != 4'h0
      |-> ##2 ((lk.flags & $past(lk.set_evt, 2) & $past(lk.w1c, 2)) == ($past(lk.set_evt, 2) & $past(lk.w1c, 2))))
    else $error("clear beat a simultaneous set");

  // --------------------------------------------------------------
  // Flag clear, read data, counter and holding register checks
  // --------------------------------------------------------------
  a_w1c_late: assert property (
    flag_wr && io_wdata[t1cd_pkg::BIT_OVF] && lk.flags[t1cd_pkg::FI_OVF] && !irq_ack && !$past(flag_wr)
      |=> lk.flags[t1cd_pkg::FI_OVF])
    else $error("write one cleared overflow flag too early");

  a_rdata_hold: assert property (
    !io_re |=> $stable(io_rdata))
    else $error("read data changed without a read");

  a_cnt_load: assert property (
    cnt_wr |=> q_reg.cnt[7:0] == $past(io_wdata) && q_reg.cnt[9:8] == $past(q_reg.hb))
    else $error("counter write did not load holding and data bytes");

  a_hb_capture: assert property (
    io_re && !io_we && io_addr == t1cd_pkg::ADDR_CMPD |=> q_reg.hb == $past(q_reg.cmpd[9:8]))
    else $error("compare read did not fill the holding bits");

  a_top_wrap: assert property (
    timer_tick && !cnt_wr && !dual && q_reg.cnt >= top_eff |=> q_reg.cnt == t1cd_pkg::CNT_ZERO)
    else $error("counter did not clear at top");

  a_dual_turn: assert property (
    timer_tick && !cnt_wr && dual && !q_reg.dir_down && q_reg.cnt >= top_eff |=> q_reg.dir_down)
    else $error("dual-slope count did not turn at top");

endmodule : t1cd_timer
`default_nettype wire

// [common/t1cd_pkg.sv]
/*
  Constants for the compare-D, interrupt flag and dead-time slice of the
  10-bit timer: I/O addresses, bit positions, vectors and encodings.
  Assumes an 8-bit I/O bus on the timer's own clock.
*/
`default_nettype none
package t1cd_pkg;

  localparam int         CNT_W      = 10;
  localparam int         HB_W       = 2;
  localparam int         DT_W       = 4;
  localparam int         FL_N       = 4;
  localparam int         VEC_W      = 5;
  localparam int         ADDR_W     = 6;
  localparam int         DATA_W     = 8;

  localparam logic [5:0] ADDR_FLAGS = 6'h38;
  localparam logic [5:0] ADDR_MASK  = 6'h39;
  localparam logic [5:0] ADDR_CNT   = 6'h2E;
  localparam logic [5:0] ADDR_HB    = 6'h2F;
  localparam logic [5:0] ADDR_TOP   = 6'h2D;
  localparam logic [5:0] ADDR_CMPD  = 6'h2B;
  localparam logic [5:0] ADDR_DT    = 6'h24;

  localparam int         BIT_CMP_D  = 7;
  localparam int         BIT_CMP_A  = 6;
  localparam int         BIT_CMP_B  = 5;
  localparam int         BIT_OVF    = 2;

  localparam int         FI_D       = 3;
  localparam int         FI_A       = 2;
  localparam int         FI_B       = 1;
  localparam int         FI_OVF     = 0;

  localparam logic [4:0] VEC_CMP_D  = 5'h10;
  localparam logic [4:0] VEC_CMP_A  = 5'h03;
  localparam logic [4:0] VEC_CMP_B  = 5'h09;
  localparam logic [4:0] VEC_OVF    = 5'h04;
  localparam logic [4:0] VEC_NONE   = 5'h00;

  localparam logic [9:0] TOP_MIN    = 10'h003;
  localparam logic [9:0] CNT_ZERO   = 10'h000;
  localparam logic [9:0] CNT_ONE    = 10'h001;
  localparam logic [3:0] DT_ZERO    = 4'h0;
  localparam logic [3:0] DT_ONE     = 4'h1;

  localparam int         DT_TRUE_HI = 7;
  localparam int         DT_TRUE_LO = 4;
  localparam int         DT_COMP_HI = 3;
  localparam int         DT_COMP_LO = 0;
  localparam int         WGM_DUAL   = 0;

  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

endpackage : t1cd_pkg
`default_nettype wire

// [common/t1cd_link_if.sv]
/*
  Carrier between the timer top and its flag and dead-time modules.
  Assumes all three sit on the same clock.
*/
`default_nettype none
interface t1cd_link_if;
  logic       tick;
  logic       wave;
  logic [3:0] dt_true;
  logic [3:0] dt_comp;
  logic       out_true;
  logic       out_comp;
  logic [3:0] set_evt;
  logic [3:0] w1c;
  logic [3:0] ack;
  logic [3:0] flags;

  modport dt_src (output tick, wave, dt_true, dt_comp, input out_true, out_comp);
  modport dt_gen (input tick, wave, dt_true, dt_comp, output out_true, out_comp);
  modport fl_src (output set_evt, w1c, ack, input flags);
  modport fl_own (input set_evt, w1c, ack, output flags);
endinterface : t1cd_link_if
`default_nettype wire

// [logic/t1cd_flags.sv]
/*
  Timer interrupt flags with synchronised set and write-one clear.
  Assumes set, clear and acknowledge are single-cycle pulses on mclk.
*/
`default_nettype none
module t1cd_flags (
  input  wire logic   mclk,
  input  wire logic   rst_b,
  t1cd_link_if.fl_own lk
);
  typedef struct packed {
    logic [3:0] set_pend;
    logic [3:0] clr_pend;
    logic [3:0] flags;
  } t1cd_fl_state_t;

  t1cd_fl_state_t q_reg;
  t1cd_fl_state_t q_next;

  // --------------------------------------------------------------
  // Flag update
  // --------------------------------------------------------------
  always_comb begin
    q_next          = q_reg;
    q_next.set_pend = lk.set_evt;
    q_next.clr_pend = lk.w1c;
    q_next.flags    = (q_reg.flags & ~q_reg.clr_pend & ~lk.ack) | q_reg.set_pend;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign lk.flags = q_reg.flags;

  a_flag_set_delay: assert property (@(posedge mclk) disable iff (!rst_b)
    lk.set_evt != 4'h0 |-> ##2 ((lk.flags & $past(lk.set_evt, 2)) == $past(lk.set_evt, 2)))
    else $error("flag not set two cycles after event");
endmodule : t1cd_flags
`default_nettype wire

// [logic/t1cd_deadtime.sv]
/*
  Shared dead-time generator for one complementary output pair.
  Assumes tick is a one-cycle prescaled timer pulse on mclk.
*/
`default_nettype none
module t1cd_deadtime (
  input  wire logic   mclk,
  input  wire logic   rst_b,
  t1cd_link_if.dt_gen lk
);
  typedef struct packed {
    logic       wave_q;
    logic       busy;
    logic [3:0] cnt;
    logic       out_t;
    logic       out_c;
  } t1cd_dt_state_t;

  t1cd_dt_state_t q_reg;
  t1cd_dt_state_t q_next;

  // --------------------------------------------------------------
  // Edge delay
  // --------------------------------------------------------------
  always_comb begin
    q_next = q_reg;
    if (lk.wave != q_reg.wave_q) begin
      q_next.wave_q = lk.wave;
      q_next.out_t  = 1'b0;
      q_next.out_c  = 1'b0;
      q_next.busy   = 1'b1;
      q_next.cnt    = lk.wave ? lk.dt_true : lk.dt_comp;
    end else if (q_reg.busy) begin
      if (q_reg.cnt == t1cd_pkg::DT_ZERO) begin
        q_next.busy  = 1'b0;
        q_next.out_t = q_reg.wave_q;
        q_next.out_c = !q_reg.wave_q;
      end else if (lk.tick) begin
        q_next.cnt = q_reg.cnt - t1cd_pkg::DT_ONE;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q_reg      <= '0;
      q_reg.busy <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  assign lk.out_true = q_reg.out_t;
  assign lk.out_comp = q_reg.out_c;

  a_dt_no_overlap: assert property (@(posedge mclk) disable iff (!rst_b)
    !(lk.out_true && lk.out_comp))
    else $error("true and complement outputs overlap");

  a_dt_zero_delay: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(lk.wave) && lk.dt_true == 4'h0 ##1 lk.wave |-> ##1 lk.out_true)
    else $error("zero dead time did not pass edge");
endmodule : t1cd_deadtime
`default_nettype wire

// [testbench/t1cd_tb.sv]
/*
  Self-checking bench for the timer slice: registers, flags, vectors,
  counting, compare D and dead time.
  Assumes the timer top alone, with inputs driven at falling mclk edges.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic       mclk, rst_b, io_we, io_re, timer_tick, pwm_mode, gie;
  logic       cmp_a_evt, cmp_b_evt, irq_ack, irq_req, cmp_d_match;
  logic       overflow_evt, pwm_output, pwm_output_n;
  logic [5:0] io_addr;
  logic [7:0] io_wdata, io_rdata, rv, dv;
  logic [1:0] wgm, com_d;
  logic [4:0] irq_ack_vec, irq_vec;
  logic [9:0] counter_value, top_compare_value, tv, top;
  int         bad_count, num_checks, cycles, b1, b2, d1, d2;

  t1cd_timer t1cd_timer_inst (
    .mclk(mclk), .rst_b(rst_b), .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we),
    .io_re(io_re), .io_rdata(io_rdata), .timer_tick(timer_tick), .pwm_mode(pwm_mode), .wgm(wgm),
    .com_d(com_d), .gie(gie), .cmp_a_evt(cmp_a_evt), .cmp_b_evt(cmp_b_evt), .irq_ack(irq_ack),
    .irq_ack_vec(irq_ack_vec), .irq_req(irq_req), .irq_vec(irq_vec), .counter_value(counter_value),
    .top_compare_value(top_compare_value), .cmp_d_match(cmp_d_match), .overflow_evt(overflow_evt),
    .pwm_output(pwm_output), .pwm_output_n(pwm_output_n)
  );

  // ----------------------------------------
  // Clock and timeout
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge mclk);
    io_addr = a;
    io_wdata = d;
    io_we = 1'b1;
    @(negedge mclk);
    io_we = 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge mclk);
    io_addr = a;
    io_re = 1'b1;
    @(negedge mclk);
    io_re = 1'b0;
    d = io_rdata;
  endtask : rd

  task automatic wr10(input logic [5:0] a, input logic [9:0] v);
    wr(t1cd_pkg::ADDR_HB, {6'h00, v[9:8]});
    wr(a, v[7:0]);
  endtask : wr10

  task automatic ack(input logic [4:0] v);
    @(negedge mclk);
    irq_ack = 1'b1;
    irq_ack_vec = v;
    @(negedge mclk);
    irq_ack = 1'b0;
    repeat (2) @(negedge mclk);
  endtask : ack

  function automatic logic [4:0] exp_vec(input logic [7:0] f);
    if (f[t1cd_pkg::BIT_CMP_A]) return t1cd_pkg::VEC_CMP_A;
    if (f[t1cd_pkg::BIT_OVF]) return t1cd_pkg::VEC_OVF;
    if (f[t1cd_pkg::BIT_CMP_B]) return t1cd_pkg::VEC_CMP_B;
    if (f[t1cd_pkg::BIT_CMP_D]) return t1cd_pkg::VEC_CMP_D;
    return t1cd_pkg::VEC_NONE;
  endfunction : exp_vec

  task automatic chk_irq(input logic [7:0] f, input logic [7:0] m);
    logic [7:0] p;
    p = f & m & 8'hE4;
    chk("irq_req", gie && (p != 8'h00), irq_req);
    if (gie && p != 8'h00) chk("irq_vec", exp_vec(p), irq_vec);
  endtask : chk_irq

  task automatic run_cnt(input logic dual, input logic [9:0] tp, input logic [9:0] st,
                         input logic [9:0] cd, input int n);
    logic [9:0] e;
    logic       up;
    logic [7:0] f;
    pwm_mode = dual | 1'($urandom());
    wgm = {1'b0, dual};
    wr(t1cd_pkg::ADDR_FLAGS, 8'hFF);
    wr10(t1cd_pkg::ADDR_TOP, tp);
    wr10(t1cd_pkg::ADDR_CMPD, cd);
    wr(t1cd_pkg::ADDR_HB, {6'h00, st[9:8]});
    @(negedge mclk);
    io_addr = t1cd_pkg::ADDR_CNT;
    io_wdata = st[7:0];
    io_we = 1'b1;
    timer_tick = 1'b1;
    @(negedge mclk);
    io_we = 1'b0;
    chk("write match", 1'b0, cmp_d_match);
    chk("counter write", st, counter_value);
    chk("top_compare_value", tp, top_compare_value);
    e = st;
    up = 1'b1;
    f = 8'h00;
    repeat (n) begin
      @(negedge mclk);
      if (!dual) begin
        e = (e >= tp) ? 10'h000 : e + 10'h001;
      end else begin
        e = up ? e + 10'h001 : e - 10'h001;
        if (e == tp) up = 1'b0;
        if (e == 10'h000) up = 1'b1;
      end
      chk("counter_value", e, counter_value);
      chk("cmp_d_match", e == cd, cmp_d_match);
      chk("overflow_evt", e == 10'h000, overflow_evt);
      f[7] |= (e == cd);
      f[2] |= (e == 10'h000);
    end
    timer_tick = 1'b0;
    repeat (3) @(negedge mclk);
    rd(t1cd_pkg::ADDR_FLAGS, rv);
    chk("flags", f, rv);
    chk_irq(f, 8'hE4);
    ack(dual ? t1cd_pkg::VEC_CMP_D : t1cd_pkg::VEC_OVF);
    rd(t1cd_pkg::ADDR_FLAGS, rv);
    chk("flags after ack", f & (dual ? 8'h7F : 8'hFB), rv);
  endtask : run_cnt

  task automatic wait_hi(input int sel, output int n);
    logic s;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
      s = (sel == 0) ? cmp_d_match : (sel == 1) ? pwm_output : pwm_output_n;
    end while (s !== 1'b1 && n < 300);
    if (n >= 300) begin
      $display("[FAIL] output %0d rise expected 1 seen %b", sel, s);
      bad_count++;
    end
  endtask : wait_hi

  task automatic run_dt(input logic [7:0] dt, input logic [1:0] c1, input logic [1:0] c2,
                        output int r1, output int r2);
    int n;
    wr(t1cd_pkg::ADDR_DT, dt);
    rd(t1cd_pkg::ADDR_DT, rv);
    chk("dead_time_value", dt, rv);
    timer_tick = 1'b1;
    com_d = c1;
    wait_hi(0, n);
    wait_hi(1, r1);
    com_d = c2;
    wait_hi(0, n);
    wait_hi(2, r2);
    timer_tick = 1'b0;
  endtask : run_dt

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_b, io_we, io_re, timer_tick, pwm_mode, gie, cmp_a_evt, cmp_b_evt, irq_ack} = 9'h000;
    io_addr = 6'h00;
    io_wdata = 8'h00;
    wgm = 2'h0;
    com_d = 2'h0;
    irq_ack_vec = 5'h00;
    void'($urandom(83));
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    rd(t1cd_pkg::ADDR_FLAGS, rv);
    chk("flags reset", 8'h00, rv);
    chk("pwm_output_n reset", 1'b1, pwm_output_n);
    rd(t1cd_pkg::ADDR_MASK, rv);
    chk("mask reset", 8'h00, rv);
    rd(6'h3F, rv);
    chk("unmapped", 8'h00, rv);
    wr10(t1cd_pkg::ADDR_TOP, 10'h001);
    rd(t1cd_pkg::ADDR_TOP, rv);
    rd(t1cd_pkg::ADDR_HB, dv);
    chk("top floor", 10'h003, {dv[1:0], rv});
    chk("top_compare_value", 10'h003, top_compare_value);
    tv = 10'($urandom());
    wr10(t1cd_pkg::ADDR_CMPD, tv);
    rd(t1cd_pkg::ADDR_CMPD, rv);
    rd(t1cd_pkg::ADDR_HB, dv);
    chk("compare_d_value", tv, {dv[1:0], rv});
    $display("test registers done");
    for (int k = 0; k < 8; k++) begin
      dv = 8'($urandom());
      wr(t1cd_pkg::ADDR_MASK, dv);
      rd(t1cd_pkg::ADDR_MASK, rv);
      chk("mask", dv & 8'hE4, rv);
      gie = 1'($urandom());
      tv = 10'($urandom() & 32'h60);
      @(negedge mclk);
      cmp_a_evt = tv[6];
      cmp_b_evt = tv[5];
      @(negedge mclk);
      cmp_a_evt = 1'b0;
      cmp_b_evt = 1'b0;
      @(negedge mclk);
      chk("irq early", 1'b0, irq_req);
      repeat (2) @(negedge mclk);
      rd(t1cd_pkg::ADDR_FLAGS, rv);
      chk("flags", tv, rv);
      chk_irq(tv[7:0], dv);
      wr(t1cd_pkg::ADDR_FLAGS, 8'h00);
      ack(exp_vec(tv[7:0]));
      rd(t1cd_pkg::ADDR_FLAGS, rv);
      chk("flags acked", tv[6] ? (tv & 10'h020) : 10'h000, rv);
      wr(t1cd_pkg::ADDR_FLAGS, 8'hFF);
      repeat (2) @(negedge mclk);
      rd(t1cd_pkg::ADDR_FLAGS, rv);
      chk("flags cleared", 8'h00, rv);
    end
    @(negedge mclk);
    io_addr = t1cd_pkg::ADDR_FLAGS;
    io_wdata = 8'h20;
    io_we = 1'b1;
    cmp_b_evt = 1'b1;
    @(negedge mclk);
    io_we = 1'b0;
    cmp_b_evt = 1'b0;
    repeat (3) @(negedge mclk);
    rd(t1cd_pkg::ADDR_FLAGS, rv);
    chk("set beats clear", 8'h20, rv);
    $display("test flags done");
    wr(t1cd_pkg::ADDR_MASK, 8'hE4);
    gie = 1'b1;
    run_cnt(1'b0, 10'h003, 10'h000, 10'h000, 10);
    for (int k = 0; k < 3; k++) begin
      top = 10'($urandom_range(1023, 3));
      run_cnt(1'b0, top, top - 10'h003, top - 10'($urandom_range(3, 0)), 8);
      top = 10'($urandom_range(12, 3));
      run_cnt(1'b1, top, 10'h000, 10'($urandom_range(32'(top), 0)), 3 * int'(top));
    end
    $display("test counter done");
    pwm_mode = 1'b0;
    wgm = 2'h0;
    wr10(t1cd_pkg::ADDR_TOP, 10'h040);
    wr10(t1cd_pkg::ADDR_CMPD, 10'h010);
    run_dt(8'h00, t1cd_pkg::COM_TOGGLE, t1cd_pkg::COM_TOGGLE, b1, b2);
    for (int k = 0; k < 3; k++) begin
      dv = (k == 0) ? 8'hF0 : 8'($urandom());
      run_dt(dv, t1cd_pkg::COM_SET, t1cd_pkg::COM_CLEAR, d1, d2);
      chk("true delay", 10'(b1 + dv[7:4]), 10'(d1));
      chk("comp delay", 10'(b2 + dv[3:0]), 10'(d2));
    end
    $display("test dead time done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
